// File: design/flash_host_defines.svh
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
// ****************************************
// Widths
// ****************************************
`define FH_AW 22
`define FH_DW 16
`define FH_CNT_W 4
// ****************************************
// Register offsets and fields
// ****************************************
`define FH_CTRL_OFS 8'h00
`define FH_ADDR_OFS 8'h04
`define FH_WDATA_OFS 8'h08
`define FH_STAT_OFS 8'h0c
`define FH_RDATA_OFS 8'h10
`define FH_GO_BIT 0
`define FH_OP_MSB 7
`define FH_OP_LSB 4
`define FH_BYTE_BIT 8
`define FH_ACCEL_BIT 9
`define FH_ST_BUSY 0
`define FH_ST_BYPASS 1
`define FH_ST_AUTOSEL 2
`define FH_ST_SECURE 3
`define FH_ST_TIMEOUT 4
`define FH_ST_REFUSED 5
`define FH_ST_DONE 6
// ****************************************
// Operations
// ****************************************
`define FH_OP_RESET 4'h0
`define FH_OP_AUTOSEL 4'h1
`define FH_OP_PROG 4'h2
`define FH_OP_BYP_ENTER 4'h3
`define FH_OP_BYP_PROG 4'h4
`define FH_OP_BYP_EXIT 4'h5
`define FH_OP_SEC_ENTER 4'h6
`define FH_OP_SEC_EXIT 4'h7
`define FH_OP_READ 4'h8
// ****************************************
// Command words
// ****************************************
`define FH_UNLOCK1_ADDR 22'h000555
`define FH_UNLOCK2_ADDR 22'h0002aa
`define FH_UNLOCK1_DATA 16'h00aa
`define FH_UNLOCK2_DATA 16'h0055
`define FH_BANK_MASK 22'h300000
`define FH_CMD_RESET 16'h00f0
`define FH_CMD_AUTOSEL 16'h0090
`define FH_CMD_PROG 16'h00a0
`define FH_CMD_BYPASS 16'h0020
`define FH_CMD_SEC_ENTER 16'h0088
`define FH_CMD_EXIT1 16'h0090
`define FH_CMD_EXIT2 16'h0000
`define FH_POLL_BIT 7
`define FH_TIMEOUT_BIT 5
// ****************************************
// Timing
// ****************************************
`define FH_CLK_NS 50
`define FH_TWP_NS 35
`define FH_TACC_NS 70
`define FH_SYNC_CYC 3
`define FH_TWP_CYC ((`FH_TWP_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_TACC_CYC (((`FH_TACC_NS + `FH_CLK_NS - 1) / `FH_CLK_NS) + `FH_SYNC_CYC)
`endif

// File: design/flash_host_pkg.sv
`include "flash_host_defines.svh"
package flash_host_pkg;
  typedef enum logic [2:0] {S_IDLE, S_WSETUP, S_WLOW, S_WHIGH, S_RSETUP, S_RWAIT} fsm_t;
  typedef struct packed {
    logic last;
    logic [`FH_AW-1:0] addr;
    logic [`FH_DW-1:0] data;
  } cyc_t;
  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic dqDrvN;
    logic widthSelectN;
    logic accelHv;
    logic [`FH_AW-1:0] addr;
    logic [`FH_DW-1:0] dqOut;
  } pins_t;
  typedef struct packed {
    fsm_t st;
    logic [3:0] op;
    logic [2:0] step;
    logic [`FH_CNT_W-1:0] cnt;
    logic [`FH_AW-1:0] addrReg;
    logic [`FH_DW-1:0] wdataReg;
    logic [`FH_DW-1:0] rdataReg;
    logic busy, bypass, autosel, secure, timeout, refused, done, dq5Seen;
    pins_t pin;
    logic [`FH_DW-1:0] dqS1, dqS2, dqS3, dqSt;
    logic rbS1, rbS2, rbS3, rbSt;
    logic [31:0] hrdata;
    logic hreadyout;
    logic wrPend;
    logic [7:0] wrOfs;
  } state_t;
endpackage

// File: design/nor_flash_host.sv
`timescale 1ns/1ns
`include "flash_host_defines.svh"
// Notes on behaviour
// - Write strobe goes low only with chip select low and output gate high.
// - Host issues reset after a timeout flag or to leave autoselect.
// - Host writes autoselect only to an idle bank in read mode.
// - Program is two unlocks, setup, then address and data at chosen width.
// - Two unlocks then 20h enter bypass; bypass program is A0h then data.
// - Bypass accepts only program, exit and read; exit is 90h at bank, then 00h.
module nor_flash_host
  import flash_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [`FH_AW-1:0] flashAddr,
  output logic [`FH_DW-1:0] dqOut,
  output logic dqOeN,
  input wire logic [`FH_DW-1:0] dqIn,
  output logic widthSelectN,
  output logic protectAccelHv,
  input wire logic readyBusyN
);
  state_t s_r, s_nxt;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic cyc_t mk(input logic l, input logic [`FH_AW-1:0] a,
                              input logic [`FH_DW-1:0] d);
    cyc_t c;
    c.last = l;
    c.addr = a;
    c.data = d;
    return c;
  endfunction

  // Write cycle for an operation at a given step
  function automatic cyc_t seqCyc(input logic [3:0] op, input logic [2:0] step,
                                  input logic [`FH_AW-1:0] a, input logic [`FH_DW-1:0] d);
    logic [`FH_AW-1:0] bank;
    bank = (a & `FH_BANK_MASK) | `FH_UNLOCK1_ADDR;
    seqCyc = mk(1'b1, a, `FH_CMD_RESET);
    if (step == 3'h0 && op != `FH_OP_RESET && op != `FH_OP_BYP_PROG && op != `FH_OP_BYP_EXIT) begin
      seqCyc = mk(1'b0, `FH_UNLOCK1_ADDR, `FH_UNLOCK1_DATA);
    end else if (step == 3'h1 && (op == `FH_OP_BYP_PROG || op == `FH_OP_BYP_EXIT)) begin
      seqCyc = mk(1'b1, op == `FH_OP_BYP_PROG ? a : bank,
                  op == `FH_OP_BYP_PROG ? d : `FH_CMD_EXIT2);
    end else if (step == 3'h0) begin
      case (op)
        `FH_OP_BYP_PROG: seqCyc = mk(1'b0, `FH_UNLOCK1_ADDR, `FH_CMD_PROG);
        `FH_OP_BYP_EXIT: seqCyc = mk(1'b0, bank, `FH_CMD_EXIT1);
        default: seqCyc = mk(1'b1, a, `FH_CMD_RESET);
      endcase
    end else if (step == 3'h1) begin
      seqCyc = mk(1'b0, `FH_UNLOCK2_ADDR, `FH_UNLOCK2_DATA);
    end else if (step == 3'h2) begin
      case (op)
        `FH_OP_AUTOSEL: seqCyc = mk(1'b1, bank, `FH_CMD_AUTOSEL);
        `FH_OP_PROG: seqCyc = mk(1'b0, `FH_UNLOCK1_ADDR, `FH_CMD_PROG);
        `FH_OP_BYP_ENTER: seqCyc = mk(1'b1, `FH_UNLOCK1_ADDR, `FH_CMD_BYPASS);
        `FH_OP_SEC_ENTER: seqCyc = mk(1'b1, `FH_UNLOCK1_ADDR, `FH_CMD_SEC_ENTER);
        default: seqCyc = mk(1'b0, `FH_UNLOCK1_ADDR, `FH_CMD_EXIT1);
      endcase
    end else begin
      seqCyc = mk(1'b1, op == `FH_OP_PROG ? a : `FH_UNLOCK1_ADDR,
                  op == `FH_OP_PROG ? d : `FH_CMD_EXIT2);
    end
  endfunction

  // Which operations the device accepts in the present mode
  function automatic logic opLegal(input logic [3:0] op, input logic byp, input logic as);
    if (byp) begin
      opLegal = op == `FH_OP_BYP_PROG || op == `FH_OP_BYP_EXIT || op == `FH_OP_READ;
    end else if (as) begin
      opLegal = op == `FH_OP_RESET || op == `FH_OP_READ;
    end else begin
      opLegal = op != `FH_OP_BYP_PROG && op != `FH_OP_BYP_EXIT && op <= `FH_OP_READ;
    end
  endfunction

  logic bypEff;
  cyc_t curCyc;
  logic addrPhase;
  logic [31:0] statWord;
  assign bypEff = s_r.bypass | s_r.pin.accelHv;
  assign curCyc = seqCyc(s_r.op, s_r.step, s_r.addrReg, s_r.wdataReg);
  assign addrPhase = hsel & hready & htrans[1];
  assign statWord = {24'h0, s_r.rbSt, s_r.done, s_r.refused, s_r.timeout, s_r.secure,
                     s_r.autosel, bypEff, s_r.busy};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.dqS1 = dqIn;
    s_nxt.dqS2 = s_r.dqS1;
    s_nxt.dqS3 = s_r.dqS2;
    s_nxt.rbS1 = readyBusyN;
    s_nxt.rbS2 = s_r.rbS1;
    s_nxt.rbS3 = s_r.rbS2;
    if (s_r.dqS2 == s_r.dqS3) begin
      s_nxt.dqSt = s_r.dqS3;
    end
    if (s_r.rbS2 == s_r.rbS3) begin
      s_nxt.rbSt = s_r.rbS3;
    end
    s_nxt.hreadyout = 1'b1;
    s_nxt.wrPend = addrPhase & hwrite;
    s_nxt.wrOfs = haddr[7:0];
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        `FH_ADDR_OFS: s_nxt.hrdata = {10'h0, s_r.addrReg};
        `FH_WDATA_OFS: s_nxt.hrdata = {16'h0, s_r.wdataReg};
        `FH_STAT_OFS: s_nxt.hrdata = statWord;
        `FH_RDATA_OFS: s_nxt.hrdata = {16'h0, s_r.rdataReg};
        `FH_CTRL_OFS: s_nxt.hrdata = {22'h0, s_r.pin.accelHv, ~s_r.pin.widthSelectN,
                                      s_r.op, 4'h0};
        default: s_nxt.hrdata = 32'h0;
      endcase
    end
    if (s_r.wrPend) begin
      case (s_r.wrOfs)
        `FH_ADDR_OFS: if (!s_r.busy) s_nxt.addrReg = hwdata[`FH_AW-1:0];
        `FH_WDATA_OFS: if (!s_r.busy) s_nxt.wdataReg = hwdata[`FH_DW-1:0];
        `FH_STAT_OFS: begin
          if (hwdata[`FH_ST_TIMEOUT]) s_nxt.timeout = 1'b0;
          if (hwdata[`FH_ST_REFUSED]) s_nxt.refused = 1'b0;
        end
        `FH_CTRL_OFS: begin
          if (s_r.busy) begin
            if (hwdata[`FH_GO_BIT]) s_nxt.refused = 1'b1;
          end else begin
            s_nxt.pin.widthSelectN = ~hwdata[`FH_BYTE_BIT];
            s_nxt.pin.accelHv = hwdata[`FH_ACCEL_BIT];
            if (hwdata[`FH_GO_BIT]) begin
              if (opLegal(hwdata[`FH_OP_MSB:`FH_OP_LSB], bypEff | hwdata[`FH_ACCEL_BIT],
                          s_r.autosel)) begin
                s_nxt.op = hwdata[`FH_OP_MSB:`FH_OP_LSB];
                s_nxt.step = 3'h0;
                s_nxt.busy = 1'b1;
                s_nxt.done = 1'b0;
                s_nxt.dq5Seen = 1'b0;
                s_nxt.st = hwdata[`FH_OP_MSB:`FH_OP_LSB] == `FH_OP_READ ? S_RSETUP : S_WSETUP;
              end else begin
                s_nxt.refused = 1'b1;
              end
            end
          end
        end
        default: ;
      endcase
    end
    case (s_r.st)
      S_IDLE: ;
      S_WSETUP: begin
        s_nxt.pin.ceN = 1'b0;
        s_nxt.pin.oeN = 1'b1;
        s_nxt.pin.addr = curCyc.addr;
        s_nxt.pin.dqOut = curCyc.data;
        s_nxt.pin.dqDrvN = 1'b0;
        s_nxt.st = S_WLOW;
        s_nxt.cnt = `FH_CNT_W'(`FH_TWP_CYC);
      end
      S_WLOW: begin
        s_nxt.pin.weN = 1'b0;
        s_nxt.cnt = s_r.cnt - `FH_CNT_W'(1);
        if (s_r.cnt == `FH_CNT_W'(1)) begin
          s_nxt.st = S_WHIGH;
        end
      end
      S_WHIGH: begin
        s_nxt.pin.weN = 1'b1;
        s_nxt.pin.ceN = 1'b1;
        s_nxt.st = S_WSETUP;
        s_nxt.step = s_r.step + 3'h1;
        if (curCyc.last) begin
          s_nxt.st = S_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          case (s_r.op)
            `FH_OP_RESET: begin
              s_nxt.autosel = 1'b0;
              s_nxt.bypass = 1'b0;
            end
            `FH_OP_AUTOSEL: s_nxt.autosel = 1'b1;
            `FH_OP_BYP_ENTER: s_nxt.bypass = 1'b1;
            `FH_OP_BYP_EXIT: s_nxt.bypass = 1'b0;
            `FH_OP_SEC_ENTER: s_nxt.secure = 1'b1;
            `FH_OP_SEC_EXIT: s_nxt.secure = 1'b0;
            `FH_OP_PROG, `FH_OP_BYP_PROG: begin
              s_nxt.st = S_RSETUP;
              s_nxt.busy = 1'b1;
              s_nxt.done = 1'b0;
            end
            default: ;
          endcase
        end
      end
      S_RSETUP: begin
        s_nxt.pin.dqDrvN = 1'b1;
        s_nxt.pin.ceN = 1'b0;
        s_nxt.pin.oeN = 1'b0;
        s_nxt.pin.addr = s_r.addrReg;
        s_nxt.cnt = `FH_CNT_W'(`FH_TACC_CYC);
        s_nxt.st = S_RWAIT;
      end
      S_RWAIT: begin
        s_nxt.cnt = s_r.cnt - `FH_CNT_W'(1);
        if (s_r.cnt == `FH_CNT_W'(1)) begin
          s_nxt.pin.ceN = 1'b1;
          s_nxt.pin.oeN = 1'b1;
          s_nxt.st = S_RSETUP;
          s_nxt.rdataReg = s_r.dqSt;
          if (s_r.op == `FH_OP_READ || s_r.dqSt[`FH_POLL_BIT] == s_r.wdataReg[`FH_POLL_BIT]) begin
            s_nxt.st = S_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end else if (s_r.dqSt[`FH_TIMEOUT_BIT]) begin
            s_nxt.dq5Seen = 1'b1;
            if (s_r.dq5Seen) begin
              s_nxt.timeout = 1'b1;
              s_nxt.op = `FH_OP_RESET;
              s_nxt.step = 3'h0;
              s_nxt.st = S_WSETUP;
            end
          end
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      s_r.pin.ceN <= 1'b1;
      s_r.pin.oeN <= 1'b1;
      s_r.pin.weN <= 1'b1;
      s_r.pin.dqDrvN <= 1'b1;
      s_r.pin.widthSelectN <= 1'b1;
      s_r.hreadyout <= 1'b1;
      s_r.rbS1 <= 1'b1;
      s_r.rbS2 <= 1'b1;
      s_r.rbS3 <= 1'b1;
      s_r.rbSt <= 1'b1;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.wrPend & 1'b0;
  assign flashCeN = s_r.pin.ceN;
  assign flashOeN = s_r.pin.oeN;
  assign flashWeN = s_r.pin.weN;
  assign flashAddr = s_r.pin.addr;
  assign dqOut = s_r.pin.dqOut;
  assign dqOeN = s_r.pin.dqDrvN;
  assign widthSelectN = s_r.pin.widthSelectN;
  assign protectAccelHv = s_r.pin.accelHv;

  // ****************************************
  // Assertions
  // ****************************************
  property p_wrcombo;
    @(posedge core_clk) disable iff (!rstn) !flashWeN |-> !flashCeN && flashOeN && !dqOeN;
  endproperty
  a_wrcombo: assert property (p_wrcombo) else $error("write strobe outside write combination");
  property p_pwrup;
    @(posedge core_clk) disable iff (!rstn) $rose(rstn) |-> flashWeN && flashCeN;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("strobes active at reset release");
  property p_stable;
    @(posedge core_clk) disable iff (!rstn)
      ($fell(flashWeN) || $rose(flashWeN)) |-> $stable(flashAddr) && $stable(dqOut);
  endproperty
  a_stable: assert property (p_stable) else $error("address or data moved in write pulse");
  property p_prog_poll;
    @(posedge core_clk) disable iff (!rstn)
      (clkEn && s_r.st == S_WHIGH && curCyc.last && s_r.op == `FH_OP_PROG)
        |=> s_r.st == S_RSETUP && s_r.busy;
  endproperty
  a_prog_poll: assert property (p_prog_poll) else $error("program not followed by poll");
  property p_byp_enter;
    @(posedge core_clk) disable iff (!rstn)
      (clkEn && s_r.st == S_WHIGH && curCyc.last && s_r.op == `FH_OP_BYP_ENTER) |=> bypEff;
  endproperty
  a_byp_enter: assert property (p_byp_enter) else $error("bypass not entered");
  property p_byp_only;
    @(posedge core_clk) disable iff (!rstn)
      (bypEff && $rose(s_r.busy)) |-> s_r.op inside {`FH_OP_BYP_PROG, `FH_OP_BYP_EXIT, `FH_OP_READ};
  endproperty
  a_byp_only: assert property (p_byp_only) else $error("illegal op in bypass");
  property p_tmo_reset;
    @(posedge core_clk) disable iff (!rstn)
      $rose(s_r.timeout) |-> s_r.op == `FH_OP_RESET && s_r.st == S_WSETUP;
  endproperty
  a_tmo_reset: assert property (p_tmo_reset) else $error("timeout without reset command");
  property p_as_exit;
    @(posedge core_clk) disable iff (!rstn) $fell(s_r.autosel) |-> $past(s_r.op) == `FH_OP_RESET;
  endproperty
  a_as_exit: assert property (p_as_exit) else $error("autoselect left without reset");
  property p_accel;
    @(posedge core_clk) disable iff (!rstn)
      (clkEn && s_r.wrPend && s_r.wrOfs == `FH_CTRL_OFS && !s_r.busy && !s_r.autosel &&
       hwdata[`FH_GO_BIT] && hwdata[`FH_ACCEL_BIT] &&
       hwdata[`FH_OP_MSB:`FH_OP_LSB] == `FH_OP_BYP_PROG)
        |=> protectAccelHv && s_r.busy && s_r.op == `FH_OP_BYP_PROG;
  endproperty
  a_accel: assert property (p_accel) else $error("accelerate level without bypass");
  c_prog: cover property (@(posedge core_clk) s_r.op == `FH_OP_PROG && $fell(s_r.busy));
  c_tmo: cover property (@(posedge core_clk) $rose(s_r.timeout));
  c_as: cover property (@(posedge core_clk) $rose(s_r.autosel));
  c_byp: cover property (@(posedge core_clk) s_r.op == `FH_OP_BYP_PROG && $fell(s_r.busy));
endmodule

// File: sim/flash_dev_model.sv
`timescale 1ns/1ns
`include "flash_host_defines.svh"
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int PROG_NS = 3000,
  parameter logic [15:0] MAKER_CODE = 16'h00c3, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0b7e // Arbitrary value
)(
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [21:0] addr,
  input wire logic [15:0] dqOut,
  input wire logic dqOeN,
  input wire logic accelHv,
  output logic [15:0] dqIn,
  output logic readyBusyN,
  output logic violation
);
  // ****************************************
  // Command state
  // ****************************************
  logic [15:0] mem [0:255];
  logic [1:0] mode;
  logic [2:0] step;
  logic secure, busy, stuck, progNext, armed;
  logic [21:0] aLat, pA;
  logic [15:0] pD, rdVal, lastVal;
  event progEv;
  wire inByp = mode == 2'd2 || accelHv;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    mode = 2'd0;
    {step, secure, busy, stuck, progNext, armed, violation} = '0;
    {aLat, pA, pD, lastVal} = '0;
  end
  assign readyBusyN = !busy;
  assign dqIn = !dqOeN ? dqOut : (!ceN && !oeN) ? rdVal : ~lastVal;
  always @(negedge weN or negedge ceN) begin
    if (!weN && !ceN && oeN) begin
      aLat = addr;
      armed = 1'b1;
    end
    if (!weN && !ceN && !oeN) violation = 1'b1;
  end
  always @(posedge weN or posedge ceN) if (armed) begin
    armed = 1'b0;
    decode(aLat, dqOut);
  end
  always @(posedge oeN) lastVal = rdVal;
  always @(progEv) begin
    #(PROG_NS);
    if ((mem[pA[7:0]] & pD) != pD) stuck = 1'b1;
    mem[pA[7:0]] = mem[pA[7:0]] & pD;
    if (!stuck) busy = 1'b0;
  end
  // ****************************************
  // Decoding and reads
  // ****************************************
  task automatic decode(input logic [21:0] a, input logic [15:0] d);
    logic u1, u2;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2aa;
    if (busy) begin
      if (stuck && d == `FH_CMD_RESET) {busy, stuck, mode, step} = '0;
      return;
    end
    if (progNext) begin
      pA = a;
      pD = d;
      busy = 1'b1;
      progNext = 1'b0;
      step = 3'd0;
      ->progEv;
    end else if (inByp) begin
      if (step == 0 && d == 16'h00a0) progNext = 1'b1;
      else if (step == 0 && d == 16'h0090) step = 3'd5;
      else begin
        if (step == 5 && d == 16'h0000) mode = 2'd0;
        step = 3'd0;
      end
    end else if (d == `FH_CMD_RESET) {mode, step} = '0;
    else if (mode == 2'd1) step = 3'd0;
    else if (step == 0 && u1 && d == `FH_UNLOCK1_DATA) step = 3'd1;
    else if (step == 1 && u2 && d == `FH_UNLOCK2_DATA) step = 3'd2;
    else if (step == 2 && u1) begin
      step = 3'd0;
      case (d)
        16'h0090: if (secure) step = 3'd3; else mode = 2'd1;
        16'h00a0: progNext = 1'b1;
        16'h0020: mode = 2'd2;
        `FH_CMD_SEC_ENTER: secure = 1'b1;
        default: ;
      endcase
    end else if (step == 3 && d == 16'h0000) {secure, step} = '0;
    else step = 3'd0;
  endtask
  function automatic logic [15:0] rdf(input logic [21:0] a);
    logic [15:0] m;
    m = mem[a[7:0]];
    if (busy && a == pA) return {m[15:8], ~pD[7], m[6], stuck, m[4:0]};
    if (mode == 2'd1) begin
      if (a[7:0] == 8'h00) return MAKER_CODE;
      if (a[7:0] == 8'h01) return DEVICE_CODE;
      return {15'h0, a[19] && a[7:0] == 8'h02};
    end
    if (secure && a[21:3] == 0) return 16'h5e00 | a[2:0];
    return m;
  endfunction
  always @(ceN, oeN, addr, busy, stuck, mode, secure) rdVal = rdf(addr);
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import flash_host_pkg::*;
  localparam logic [15:0] MAKER = 16'h00c3; // Arbitrary value
  localparam logic [15:0] DEVID = 16'h0b7e; // Arbitrary value
  logic core_clk, rstn, hsel, hwrite, hreadyout, hresp, ceN, oeN, weN, dqOeN;
  logic accelHv, readyBusyN, violation, wsN;
  logic [31:0] haddr, hwdata, hrdata, rd, sts;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [21:0] fAddr;
  logic [15:0] dqOut, dqIn;
  int fails, comparisons;
  nor_flash_host i_nor_flash_host(.core_clk(core_clk), .rstn(rstn), .clkEn(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashAddr(fAddr),
    .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn), .widthSelectN(wsN),
    .protectAccelHv(accelHv), .readyBusyN(readyBusyN));
  flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) i_flash_dev_model(
    .ceN(ceN), .oeN(oeN), .weN(weN), .addr(fAddr), .dqOut(dqOut), .dqOeN(dqOeN),
    .accelHv(accelHv), .dqIn(dqIn), .readyBusyN(readyBusyN), .violation(violation));
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic test_end(input string name);
    $display("Test %s finished, mismatches so far %0d", name, fails);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        test_done();
      end
      @(posedge core_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic op(input logic [3:0] code, input logic [21:0] a, input logic [15:0] d,
                    input logic accel);
    int n;
    n = 0;
    bus(1'b1, 8'h04, {10'h0, a});
    bus(1'b1, 8'h08, {16'h0, d});
    bus(1'b1, 8'h00, {22'h0, accel, 1'b0, code, 3'h0, 1'b1});
    bus(1'b0, 8'h0c, 32'h0);
    do begin
      bus(1'b0, 8'h0c, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      fails++;
      test_done();
    end
    sts = rd;
    bus(1'b0, 8'h10, 32'h0);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    fails = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h80);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    op(4'h8, 22'h10, 16'h0, 1'b0);
    check(rd, 32'hffff);
    test_end("reset");
    op(4'h2, 22'h10, 16'h1234, 1'b0);
    check(sts[6:0], 7'h40);
    check(sts[7], 1'b1);
    op(4'h8, 22'h10, 16'h0, 1'b0);
    check(rd, 32'h1234);
    op(4'h2, 22'h10, 16'hffff, 1'b0);
    check(sts[4], 1'b1);
    bus(1'b1, 8'h0c, 32'h30);
    op(4'h8, 22'h10, 16'h0, 1'b0);
    check(rd, 32'h1234);
    check(sts[5:4], 2'b00);
    test_end("program");
    op(4'h1, 22'h0, 16'h0, 1'b0);
    check(sts[2], 1'b1);
    op(4'h8, 22'h0, 16'h0, 1'b0);
    check(rd, {16'h0, MAKER});
    op(4'h8, 22'h1, 16'h0, 1'b0);
    check(rd, {16'h0, DEVID});
    op(4'h8, 22'h080002, 16'h0, 1'b0);
    check(rd, 32'h1);
    op(4'h8, 22'h000002, 16'h0, 1'b0);
    check(rd, 32'h0);
    op(4'h2, 22'h10, 16'h0, 1'b0);
    check(sts[5], 1'b1);
    bus(1'b1, 8'h0c, 32'h20);
    op(4'h0, 22'h3abcde, 16'h0, 1'b0);
    check(sts[5:0], 6'h0);
    op(4'h8, 22'h10, 16'h0, 1'b0);
    check(rd, 32'h1234);
    test_end("autoselect");
    op(4'h3, 22'h0, 16'h0, 1'b0);
    check(sts[1], 1'b1);
    op(4'h4, 22'h20, 16'h00a5, 1'b0);
    op(4'h8, 22'h20, 16'h0, 1'b0);
    check(rd, 32'h00a5);
    op(4'h2, 22'h20, 16'h0, 1'b0);
    check(sts[5], 1'b1);
    bus(1'b1, 8'h0c, 32'h20);
    op(4'h5, 22'h0, 16'h0, 1'b0);
    check(sts[1], 1'b0);
    op(4'h8, 22'h10, 16'h0, 1'b0);
    check(rd, 32'h1234);
    op(4'h4, 22'h30, 16'h0f0f, 1'b1);
    check(sts[1], 1'b1);
    op(4'h8, 22'h30, 16'h0, 1'b0);
    check(rd, 32'h0f0f);
    check(sts[1], 1'b0);
    test_end("bypass");
    op(4'h6, 22'h0, 16'h0, 1'b0);
    check(sts[3], 1'b1);
    op(4'h8, 22'h3, 16'h0, 1'b0);
    check(rd, 32'h5e03);
    op(4'h7, 22'h0, 16'h0, 1'b0);
    check(sts[3], 1'b0);
    op(4'h8, 22'h3, 16'h0, 1'b0);
    check(rd, 32'hffff);
    bus(1'b1, 8'h00, 32'h100);
    bus(1'b0, 8'h00, 32'h0);
    check(rd[9:8], 2'b01);
    check(wsN, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    @(posedge core_clk);
    check(wsN, 1'b1);
    check(violation, 1'b0);
    check(hresp, 1'b0);
    test_end("security");
    test_done();
  end
endmodule
